/* rtl/ext_cap_pkg.sv */
/*
  constants for the extended capability register bank: byte offsets, field values
  and reset values.
  assumes a 32-bit axi4-lite register bus, one aligned word per register.
*/
package ext_cap_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [11:0] OFS_HDR_WORD0 = 12'h11c;
  localparam logic [11:0] OFS_HDR_WORD1 = 12'h120;
  localparam logic [11:0] OFS_HDR_WORD2 = 12'h124;
  localparam logic [11:0] OFS_HDR_WORD3 = 12'h128;
  localparam logic [11:0] OFS_ERR_CTRL = 12'h118;
  localparam logic [11:0] OFS_ERR_STATUS = 12'h104;
  localparam logic [11:0] OFS_SERIAL_CAP = 12'h180;
  localparam logic [11:0] OFS_SERIAL_LOW = 12'h184;
  localparam logic [11:0] OFS_SERIAL_HIGH = 12'h188;
  localparam logic [11:0] OFS_CHAN_CAP = 12'h200;
  localparam logic [11:0] OFS_CHAN_CAP_ONE = 12'h204;
  localparam logic [11:0] OFS_CHAN_CAP_TWO = 12'h208;
  localparam logic [11:0] OFS_CHAN_CTRL = 12'h20c;

  // ************************************************************
  // field values and reset values
  // ************************************************************
  localparam logic [15:0] SERIAL_CAP_ID = 16'h0003;
  localparam logic [15:0] CHAN_CAP_ID = 16'h0002;
  localparam logic [3:0] CAP_VERSION = 4'h1;
  localparam logic [11:0] SERIAL_NEXT_RST = 12'h200;
  localparam logic [11:0] CHAN_NEXT_RST = 12'h000;
  localparam logic [2:0] EXT_CHAN_COUNT_RST = 3'h0;
  localparam logic [2:0] LOW_PRIO_COUNT_RST = 3'h0;
  localparam logic [1:0] ENTRY_SIZE_RST = 2'h2;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [3:0] CHAN_CTRL_MASK = 4'hf;
  localparam int HDR_WORDS = 4;
  localparam int ERR_BITS = 32;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : ext_cap_pkg

/* rtl/ext_cap_regs.sv */
/*
  extended capability register bank for one switch port: error header
  log, serial number capability and port channel capability / control.
  assumes an axi4-lite master with at most one write and one read in
  flight, and error-source logic that pulses err_report with the header.
*/
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
// Summary of operation
// - on the first reported uncorrectable error the four header words are captured.
// - header word one sits at 0x11c and words two to four follow up to 0x128.
// - the serial capability header returns identifier 0x3 in bits 15:0.
// - both capability headers return version 0x1 in bits 19:16.
// - each header carries a next link in bits 31:20, zero ending the list.
// - the 64-bit unique identifier is split low word at 0x184, high at 0x188.
// - the channel capability header returns identifier 0x2 in bits 15:0.
// - the extended channel count in bits 2:0 resets to zero.
// - the low-priority channel count in bits 6:4 resets to zero and does nothing.
// - the arbitration time base in bits 9:8 is read-only zero.
// - the arbitration entry size in bits 11:10 resets to 0x2, four-bit entries.
// - the channel arbitration ability in bits 7:0 of capability two reads zero.
// - the channel table offset in bits 31:24 reads zero.
// - load bit 0 and select bits 3:1 are writable but change no behaviour.
// - a 5-bit first error index names the status bit, valid while it stays set.
module ext_cap_regs
  import ext_cap_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  // clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hot_resetn,
  // error source
  input wire logic err_report,
  input wire logic [4:0] err_index,
  input wire logic [127:0] err_header,
  // axi4-lite write address
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // error status summary
  output logic log_valid
);

  if (ADDR_WIDTH < 12) begin : g_bad_width
    $error("ADDR_WIDTH must be at least 12");
  end

  // ************************************************************
  // elaboration checks
  // ************************************************************
  // the decode below relies on this layout; a constant edited into a
  // different shape must stop the build rather than alias two registers
  if (ADDR_WIDTH > 32) begin : g_wide_addr
    $error("ADDR_WIDTH must not exceed 32");
  end

  if (ERR_BITS != 32) begin : g_bad_err_bits
    $error("error status must be one 32-bit word");
  end

  if (HDR_WORDS != 4) begin : g_bad_hdr_words
    $error("header log must hold four words");
  end

  if (OFS_HDR_WORD1 != OFS_HDR_WORD0 + 12'h004) begin : g_bad_hdr_one
    $error("header word one must follow word zero");
  end

  if (OFS_HDR_WORD2 != OFS_HDR_WORD0 + 12'h008) begin : g_bad_hdr_two
    $error("header word two must follow word one");
  end

  if (OFS_HDR_WORD3 != OFS_HDR_WORD0 + 12'h00c) begin : g_bad_hdr_three
    $error("header word three must follow word two");
  end

  if (OFS_SERIAL_LOW != OFS_SERIAL_CAP + 12'h004) begin : g_bad_serial_low
    $error("serial low word must follow its header");
  end

  if (OFS_SERIAL_HIGH != OFS_SERIAL_LOW + 12'h004) begin : g_bad_serial_high
    $error("serial high word must follow the low word");
  end

  if (OFS_CHAN_CAP_ONE != OFS_CHAN_CAP + 12'h004) begin : g_bad_cap_one
    $error("channel capability one must follow its header");
  end

  if (OFS_CHAN_CAP_TWO != OFS_CHAN_CAP + 12'h008) begin : g_bad_cap_two
    $error("channel capability two must follow capability one");
  end

  if (OFS_CHAN_CTRL != OFS_CHAN_CAP + 12'h00c) begin : g_bad_chan_ctrl
    $error("channel control must follow capability two");
  end

  // the bus carries whole words only, so every base offset is word aligned
  if ((OFS_HDR_WORD0[1:0] | OFS_ERR_CTRL[1:0] | OFS_ERR_STATUS[1:0]
      | OFS_SERIAL_CAP[1:0] | OFS_CHAN_CAP[1:0]) != 2'b00) begin : g_bad_align
    $error("register offsets must be word aligned");
  end

  // the error registers must not land inside the header log
  if ((OFS_ERR_CTRL >= OFS_HDR_WORD0 && OFS_ERR_CTRL <= OFS_HDR_WORD3)
      || (OFS_ERR_STATUS >= OFS_HDR_WORD0
      && OFS_ERR_STATUS <= OFS_HDR_WORD3)) begin : g_bad_err_ofs
    $error("error registers overlap the header log");
  end

  // ************************************************************
  // state
  // ************************************************************
  logic [31:0] header_log_word [HDR_WORDS];
  logic [ERR_BITS-1:0] uncorrectable_error_status;
  logic [4:0] first_error_index;
  logic [31:0] unique_identifier_half [2];
  logic [11:0] serial_next_link;
  logic [11:0] chan_next_link;
  logic [2:0] extended_channel_count;
  logic [2:0] low_priority_channel_count;
  logic [1:0] arbitration_entry_size;
  logic load_channel_table;
  logic [2:0] channel_arbitration_select;

  logic aw_held;
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // ************************************************************
  // write channel
  // ************************************************************
  // address and data are latched independently, so either may come first
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire [11:0] wr_ofs = aw_addr[11:0];
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire wr_known = (wr_ofs == OFS_HDR_WORD0) || (wr_ofs == OFS_HDR_WORD1)
    || (wr_ofs == OFS_HDR_WORD2) || (wr_ofs == OFS_HDR_WORD3)
    || (wr_ofs == OFS_ERR_CTRL) || (wr_ofs == OFS_ERR_STATUS)
    || (wr_ofs == OFS_SERIAL_CAP) || (wr_ofs == OFS_SERIAL_LOW)
    || (wr_ofs == OFS_SERIAL_HIGH) || (wr_ofs == OFS_CHAN_CAP)
    || (wr_ofs == OFS_CHAN_CAP_ONE) || (wr_ofs == OFS_CHAN_CAP_TWO)
    || (wr_ofs == OFS_CHAN_CTRL);
  wire wr_hi_zero = (aw_addr >> 12) == '0;
  wire wr_ok = wr_known && wr_hi_zero;
  // each ready is high for one cycle at a time: this halves the peak rate
  // but keeps every ready a plain flop output

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !aw_take && !s_axi_awready;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= WORD_ZERO;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !w_take && !s_axi_wready;
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // header log and first error tracking
  // ************************************************************
  // a new error is logged only while no logged status bit is still set
  wire log_held = uncorrectable_error_status[first_error_index];
  wire capture = err_report && !log_held;
  wire wr_status = do_write && wr_ok && (wr_ofs == OFS_ERR_STATUS);
  // status is write-one-to-clear; a new report in the same cycle wins
  wire [ERR_BITS-1:0] err_set = capture ? (32'h0000_0001 << err_index) : '0;
  wire [ERR_BITS-1:0] err_clr = wr_status ? (w_data & wmask) : '0;

  // sticky: only the fundamental reset clears these, hot reset leaves them
  genvar gi;
  for (gi = 0; gi < HDR_WORDS; gi++) begin : g_hdr
    wire [11:0] word_ofs = OFS_HDR_WORD0 + 12'(4 * gi);
    wire hit = do_write && wr_ok && (wr_ofs == word_ofs);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        header_log_word[gi] <= WORD_ZERO;
      end else if (capture) begin
        header_log_word[gi] <= err_header[32*gi +: 32];
      end else if (hit) begin
        header_log_word[gi] <= (header_log_word[gi] & ~wmask) | (w_data & wmask);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uncorrectable_error_status <= '0;
      first_error_index <= 5'h00;
      log_valid <= 1'b0;
    end else begin
      uncorrectable_error_status <= (uncorrectable_error_status & ~err_clr) | err_set;
      if (capture) begin
        first_error_index <= err_index;
      end
      log_valid <= capture || (log_held && !err_clr[first_error_index]);
    end
  end

  // ************************************************************
  // serial number and channel capability fields
  // ************************************************************
  for (gi = 0; gi < 2; gi++) begin : g_serial
    wire hit = do_write && wr_ok && (wr_ofs == (OFS_SERIAL_LOW + 12'(4 * gi)));
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        unique_identifier_half[gi] <= WORD_ZERO;
      end else if (hit) begin
        unique_identifier_half[gi] <= (unique_identifier_half[gi] & ~wmask) | (w_data & wmask);
      end
    end
  end

  wire wr_ser_cap = do_write && wr_ok && (wr_ofs == OFS_SERIAL_CAP) && w_strb[3] && w_strb[2];
  wire wr_chn_cap = do_write && wr_ok && (wr_ofs == OFS_CHAN_CAP) && w_strb[3] && w_strb[2];
  wire wr_cap_one = do_write && wr_ok && (wr_ofs == OFS_CHAN_CAP_ONE);
  wire wr_ctrl = do_write && wr_ok && (wr_ofs == OFS_CHAN_CTRL) && w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn || !hot_resetn) begin
      serial_next_link <= SERIAL_NEXT_RST;
      chan_next_link <= CHAN_NEXT_RST;
      extended_channel_count <= EXT_CHAN_COUNT_RST;
      low_priority_channel_count <= LOW_PRIO_COUNT_RST;
      arbitration_entry_size <= ENTRY_SIZE_RST;
      load_channel_table <= 1'b0;
      channel_arbitration_select <= 3'h0;
    end else begin
      if (wr_ser_cap) begin
        serial_next_link <= w_data[31:20];
      end
      if (wr_chn_cap) begin
        chan_next_link <= w_data[31:20];
      end
      if (wr_cap_one && w_strb[0]) begin
        extended_channel_count <= w_data[2:0];
        low_priority_channel_count <= w_data[6:4];
      end
      if (wr_cap_one && w_strb[1]) begin
        arbitration_entry_size <= w_data[11:10];
      end
      // stored and read back at OFS_CHAN_CTRL only; no other logic uses them
      if (wr_ctrl) begin
        load_channel_table <= w_data[0];
        channel_arbitration_select <= w_data[3:1];
      end
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  logic [ADDR_WIDTH-1:0] ar_addr;
  logic ar_held;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [11:0] rd_ofs = ar_addr[11:0];
  wire rd_hi_zero = (ar_addr >> 12) == '0;
  // read data are registered one cycle after the address is taken,
  // so the decode below only has to settle within one clock

  wire [31:0] serial_cap_word = {serial_next_link, CAP_VERSION, SERIAL_CAP_ID};
  wire [31:0] chan_cap_word = {chan_next_link, CAP_VERSION, CHAN_CAP_ID};
  // time base bits 9:8 and reserved bits are tied to zero
  wire [31:0] cap_one_word = {20'h0_0000, arbitration_entry_size, 2'b00,
    1'b0, low_priority_channel_count, 1'b0, extended_channel_count};
  wire [31:0] cap_two_word = WORD_ZERO;
  wire [31:0] ctrl_word = {28'h000_0000, channel_arbitration_select, load_channel_table};
  wire [31:0] err_ctrl_word = {27'h000_0000, first_error_index};

  logic [31:0] rd_word;
  logic rd_known;
  always_comb begin
    rd_word = WORD_ZERO;
    rd_known = 1'b1;
    case (rd_ofs)
      OFS_HDR_WORD0: rd_word = header_log_word[0];
      OFS_HDR_WORD1: rd_word = header_log_word[1];
      OFS_HDR_WORD2: rd_word = header_log_word[2];
      OFS_HDR_WORD3: rd_word = header_log_word[3];
      OFS_ERR_STATUS: rd_word = uncorrectable_error_status;
      OFS_ERR_CTRL: rd_word = err_ctrl_word;
      OFS_SERIAL_CAP: rd_word = serial_cap_word;
      OFS_SERIAL_LOW: rd_word = unique_identifier_half[0];
      OFS_SERIAL_HIGH: rd_word = unique_identifier_half[1];
      OFS_CHAN_CAP: rd_word = chan_cap_word;
      OFS_CHAN_CAP_ONE: rd_word = cap_one_word;
      OFS_CHAN_CAP_TWO: rd_word = cap_two_word;
      OFS_CHAN_CTRL: rd_word = ctrl_word & {28'h000_0000, CHAN_CTRL_MASK};
      default: rd_known = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_held <= 1'b0;
      ar_addr <= '0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= WORD_ZERO;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !ar_held && !ar_take && !s_axi_arready && !s_axi_rvalid;
      if (ar_take) begin
        ar_held <= 1'b1;
        ar_addr <= s_axi_araddr;
      end else if (ar_held) begin
        ar_held <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= (rd_known && rd_hi_zero) ? rd_word : WORD_ZERO;
        s_axi_rresp <= (rd_known && rd_hi_zero) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // ext_cap_regs

/* tb/ext_cap_regs_chk.sv */
/*
  checker for the capability register bank: bus answer timing and
  first-error log flag. assumes the master offers aw and w together.
*/
`timescale 1ns/100ps
module ext_cap_regs_chk
  import ext_cap_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // error source
  input wire logic err_report,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // status
  input wire logic log_valid
);
  // ************************************************************
  // sequences and assertions
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // a status clear lands one edge after the write is taken
  sequence no_clear;
    !s_axi_wvalid && !s_axi_awvalid && !$past(s_axi_wvalid) && !$past(s_axi_awvalid);
  endsequence
  chk_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_read_answer: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  chk_write_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  chk_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_log_set: assert property (err_report && !log_valid |=> log_valid)
    else $error("first error not logged");
  chk_log_hold: assert property (log_valid and no_clear |=> log_valid)
    else $error("log flag lost");
  chk_log_cause: assert property (!log_valid && !err_report |=> !log_valid)
    else $error("log flag without report");
  chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !log_valid)
    else $error("outputs active in reset");
endmodule // ext_cap_regs_chk

bind ext_cap_regs ext_cap_regs_chk ext_cap_regs_chk_inst (.*);

/* tb/pcie_ext_capability_regs_tb_top.sv */
/*
  testbench for the capability register bank: register reads and writes
  over axi4-lite, error log capture, hot and fundamental reset.
  assumes the checker is bound in by its own file.
*/
`timescale 1ns/100ps
module pcie_ext_capability_regs_tb_top;
  import ext_cap_pkg::*;
  logic aclk, aresetn, hot_resetn, err_report;
  logic [4:0] err_index;
  logic [127:0] err_header, hdr;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, log_valid;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;

  ext_cap_regs ext_cap_regs_inst (.aclk(aclk), .aresetn(aresetn), .hot_resetn(hot_resetn),
    .err_report(err_report), .err_index(err_index), .err_header(err_header),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .log_valid(log_valid));

  // ************************************************************
  // clock, timeout, report
  // ************************************************************
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      $display("wrong value at %0t: run timed out", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: response %b expected %b", $time, got, exp);
    end
  endtask

  // ************************************************************
  // bus tasks
  // ************************************************************
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    cmp_resp(s_axi_bresp, er);
  endtask

  task automatic bus_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    cmp_word(s_axi_rdata, ed);
    cmp_resp(s_axi_rresp, er);
  endtask

  task automatic report_err(input logic [4:0] idx, input logic [127:0] h);
    @(posedge aclk);
    err_report <= 1'b1;
    err_index <= idx;
    err_header <= h;
    @(posedge aclk);
    err_report <= 1'b0;
    @(posedge aclk);
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    {aresetn, err_report, err_index, err_header, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    hot_resetn = 1'b1;
    hdr = {32'hd3d3_0004, 32'hc2c2_0003, 32'hb1b1_0002, 32'ha0a0_0001};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    bus_rd(OFS_HDR_WORD0, WORD_ZERO, RESP_OKAY);
    bus_rd(OFS_SERIAL_CAP, 32'h2001_0003, RESP_OKAY);
    bus_rd(OFS_CHAN_CAP, 32'h0001_0002, RESP_OKAY);
    bus_rd(OFS_CHAN_CAP_ONE, 32'h0000_0800, RESP_OKAY);
    bus_rd(OFS_CHAN_CTRL, WORD_ZERO, RESP_OKAY);
    $display("test reset values done");
    bus_wr(OFS_CHAN_CAP_TWO, 32'hffff_ffff, 4'hf, RESP_OKAY);
    bus_rd(OFS_CHAN_CAP_TWO, WORD_ZERO, RESP_OKAY);
    bus_wr(OFS_CHAN_CAP_ONE, 32'hffff_ffff, 4'hf, RESP_OKAY);
    bus_rd(OFS_CHAN_CAP_ONE, 32'h0000_0c77, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      bus_wr(OFS_CHAN_CAP_ONE, 32'(k) << 10, 4'h2, RESP_OKAY);
      bus_rd(OFS_CHAN_CAP_ONE, (32'(k) << 10) | 32'h0000_0077, RESP_OKAY);
    end
    bus_wr(OFS_CHAN_CTRL, 32'hffff_ffff, 4'hf, RESP_OKAY);
    bus_rd(OFS_CHAN_CTRL, 32'h0000_000f, RESP_OKAY);
    bus_wr(OFS_SERIAL_CAP, 32'hffff_ffff, 4'hf, RESP_OKAY);
    bus_rd(OFS_SERIAL_CAP, 32'hfff1_0003, RESP_OKAY);
    bus_wr(OFS_SERIAL_LOW, 32'h1234_5678, 4'hf, RESP_OKAY);
    bus_wr(OFS_SERIAL_HIGH, 32'h9abc_def0, 4'hf, RESP_OKAY);
    bus_wr(OFS_SERIAL_LOW, 32'hffff_ffaa, 4'h1, RESP_OKAY);
    bus_rd(OFS_SERIAL_LOW, 32'h1234_56aa, RESP_OKAY);
    bus_rd(OFS_SERIAL_HIGH, 32'h9abc_def0, RESP_OKAY);
    bus_wr(12'h300, 32'hffff_ffff, 4'hf, RESP_SLVERR);
    bus_rd(12'h300, WORD_ZERO, RESP_SLVERR);
    $display("test register access done");
    report_err(5'd19, hdr);
    cmp_word({31'h0, log_valid}, 32'h1);
    // a later report must not overwrite the held header
    report_err(5'd3, ~hdr);
    for (int i = 0; i < HDR_WORDS; i++) begin
      bus_rd(OFS_HDR_WORD0 + 12'(4 * i), hdr[32*i +: 32], RESP_OKAY);
    end
    bus_rd(OFS_ERR_CTRL, 32'h0000_0013, RESP_OKAY);
    bus_rd(OFS_ERR_STATUS, 32'h0008_0000, RESP_OKAY);
    hot_resetn <= 1'b0;
    repeat (2) @(posedge aclk);
    hot_resetn <= 1'b1;
    bus_rd(OFS_HDR_WORD3, 32'hd3d3_0004, RESP_OKAY);
    bus_rd(OFS_SERIAL_LOW, 32'h1234_56aa, RESP_OKAY);
    bus_rd(OFS_SERIAL_CAP, 32'h2001_0003, RESP_OKAY);
    bus_rd(OFS_CHAN_CAP_ONE, 32'h0000_0800, RESP_OKAY);
    bus_wr(OFS_ERR_STATUS, 32'h0008_0000, 4'hf, RESP_OKAY);
    @(posedge aclk);
    cmp_word({31'h0, log_valid}, WORD_ZERO);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    bus_rd(OFS_HDR_WORD0, WORD_ZERO, RESP_OKAY);
    $display("test error log done");
    complete_run();
  end
endmodule // pcie_ext_capability_regs_tb_top
